// ===== design/tsr_top.sv
/*
  Digital side of a temperature sensor: conversion scheduler, buffer and
  result registers, shutdown control and the serial slave port.
  Assumes the analog converter answers a power-up request with a result
  presented alongside a done pulse; pins arrive asynchronously.
*/
`timescale 1ns/1ps
// Function
// - In normal mode start a conversion every 1.5 s timer expiry.
// - Conversion powers analog up, result after 1.2 ms, then powers down.
// - Serial port always active; latest result always readable.
// - Shutdown stops oscillator; no new conversions until cleared.
// - All-zero control word leaves shutdown and starts a conversion at once.
// - In shutdown the last completed result is still read.
// - In normal mode every access restarts the periodic timer.
// - Results go to a buffer, copied to result at first falling edge.
// - Serial traffic never aborts a running conversion.
// - Conversion ending after first falling edge stays in buffer.
// - Access end in normal mode starts a conversion unless one is running.
// - Result register is 14-bit read-only two's complement, top bit sign.
// - Read frame is 16 clocks: two zeros then 14 result bits.
// - Result shifted out MSB first, sign bit first after zeros.
// - Clock ignored while chip select high; frames repeat while low.
// - Output changes on falling edges; three-state when chip select high.
// - Write shares the read frame; input sampled on rising edges.
// - Control word loads on 16th rising edge and applies immediately.
// - Chip select rising before 16th edge discards the control word.
module tsr_top
  import tsr_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = CONV_PERIOD_CYC,
  parameter int unsigned CONVTIME_CYC = CONV_TIME_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  output logic analog_pwr,
  output logic osc_run,
  input wire logic conv_done,
  input tsr_result_t conv_data,
  output tsr_result_t temperature_result,
  output logic shutdown
);

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  tsr_pins_s meta_q, pins_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
      pins_q <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
    end else begin
      meta_q <= '{cs_n: cs_n, sclk: sclk, din: din};
      pins_q <= meta_q;
    end
  end

  // -----------------------------------------------------------------------
  // Serial port
  // -----------------------------------------------------------------------
  tsr_port_ev_s ev;

  tsr_serial_port u_port (
    .clock(clock),
    .rst_n(rst_n),
    .pins(pins_q),
    .result(temperature_result),
    .dout_o(dout_o),
    .dout_oe(dout_oe),
    .ev(ev)
  );

  // -----------------------------------------------------------------------
  // Conversion engine state
  // -----------------------------------------------------------------------
  typedef struct packed {
    tsr_conv_e st;
    logic shut;
    logic start_pend;           // Conversion requested, not yet started
    logic [31:0] period_cnt;
    logic [31:0] conv_cnt;
    tsr_result_t buffer;
    logic buf_new;              // Buffer holds a result not yet copied
    tsr_result_t result;
  } tsr_core_s;

  tsr_core_s c_q, c_d;

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    logic done;
    logic running;
    c_d = c_q;
    running = (c_q.st == TSR_CONV);
    done = running & (conv_done | (c_q.conv_cnt == 32'(CONVTIME_CYC - 1)));

    // Conversion timing runs untouched by serial traffic
    if (running) begin
      c_d.conv_cnt = c_q.conv_cnt + 32'h1;
    end
    if (done) begin
      c_d.buffer = conv_data;
      c_d.buf_new = 1'b1;
      c_d.st = c_q.shut ? TSR_SHDN : TSR_IDLE;
      c_d.conv_cnt = '0;
    end

    // Copy buffer into result only at first falling edge of an access
    if (ev.first_fall) begin
      if (done) begin
        c_d.result = c_q.buf_new ? c_q.buffer : c_q.result;
      end else if (c_q.buf_new) begin
        c_d.result = c_q.buffer;
        c_d.buf_new = 1'b0;
      end
    end

    // Periodic timer in normal mode
    if (!c_q.shut) begin
      if (c_q.period_cnt == 32'(PERIOD_CYC - 1)) begin
        c_d.period_cnt = '0;
        c_d.start_pend = 1'b1;
      end else begin
        c_d.period_cnt = c_q.period_cnt + 32'h1;
      end
    end

    // Access end in normal mode restarts the timer and, unless converting, asks for a conversion
    if (ev.access_end && !c_q.shut) begin
      c_d.period_cnt = '0;
      if (!running) begin
        c_d.start_pend = 1'b1;
      end
    end

    // Control word applies at the 16th rising edge
    if (ev.ctrl_load) begin
      if (ev.ctrl_word[CTRL_SHUTDOWN_BIT]) begin
        c_d.shut = 1'b1;
        c_d.start_pend = 1'b0;
        c_d.period_cnt = '0;
      end else if (ev.ctrl_word == CTRL_RESET && c_q.shut) begin
        c_d.shut = 1'b0;
        c_d.period_cnt = '0;
        c_d.start_pend = 1'b1;
      end
    end

    // Launch a pending conversion when the converter is free
    if (c_d.start_pend && !c_d.shut && c_d.st != TSR_CONV) begin
      c_d.st = TSR_CONV;
      c_d.start_pend = 1'b0;
      c_d.conv_cnt = '0;
    end else if (c_d.shut && c_d.st == TSR_IDLE) begin
      c_d.st = TSR_SHDN;
    end else if (!c_d.shut && c_d.st == TSR_SHDN) begin
      c_d.st = TSR_IDLE;
    end

    case (c_d.st)
      TSR_IDLE, TSR_CONV, TSR_SHDN: ;
      default: c_d.st = TSR_IDLE;
    endcase
    // Pending start request cleared when an access ends during a conversion
    if (running && c_d.st == TSR_CONV && ev.access_end) begin
      c_d.start_pend = 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= '0;
      c_q.st <= TSR_IDLE;
      c_q.shut <= 1'b0;
      c_q.start_pend <= 1'b1;
      c_q.buffer <= RESULT_RESET;
      c_q.result <= RESULT_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign temperature_result = c_q.result;
  assign analog_pwr = (c_q.st == TSR_CONV);
  assign osc_run = ~c_q.shut;
  assign shutdown = c_q.shut;

endmodule

// ===== pkg/tsr_pkg.sv
/*
  Package for the temperature sensor serial readout block: field layout,
  control word bits, frame length and conversion timing constants.
  Assumes a 50 MHz system clock.
*/
package tsr_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CONV_PERIOD_MS = 1500;  // 1.5 second period
  localparam int unsigned CONV_TIME_US = 1200;    // 1.2 ms conversion
  localparam int unsigned CONV_PERIOD_CYC = (CLK_HZ / 1000) * CONV_PERIOD_MS;
  localparam int unsigned CONV_TIME_CYC = (CLK_HZ / 1000000) * CONV_TIME_US;

  // ---------------------------------------------------------------------
  // Result and frame layout
  // ---------------------------------------------------------------------
  localparam int unsigned RESULT_W = 14;
  localparam int unsigned SIGN_BIT_POSITION = 13;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned LEAD_ZEROS = 2;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_SHUTDOWN_BIT = 13;  // Third bit sent, MSB first
  localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  typedef logic [RESULT_W-1:0] tsr_result_t;

  // Synchronised serial pins
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } tsr_pins_s;

  // Events from the serial port to the conversion engine
  typedef struct packed {
    logic first_fall;     // First falling edge of an access
    logic access_end;     // Chip select rose after an access
    logic ctrl_load;      // 16th rising edge: control word taken
    logic [CTRL_W-1:0] ctrl_word;
  } tsr_port_ev_s;

  typedef enum logic [1:0] {
    TSR_IDLE = 2'b00,
    TSR_CONV = 2'b01,
    TSR_SHDN = 2'b10
  } tsr_conv_e;

endpackage

// ===== design/tsr_serial_port.sv
/*
  Serial slave port: samples the synchronised chip select, serial clock and
  data input, shifts the frame out and the control word in.
  Assumes pins already pass through a two flip-flop synchroniser upstream.
*/
`timescale 1ns/1ps
module tsr_serial_port
  import tsr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input tsr_pins_s pins,
  input tsr_result_t result,
  output logic dout_o,
  output logic dout_oe,
  output tsr_port_ev_s ev
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic sclk_prev;
    logic active;        // Access in progress since chip select fell
    logic seen_fall;     // First falling edge of this access passed
    logic [3:0] fall_cnt;
    logic [4:0] rise_cnt;
    logic [CTRL_W-1:0] shift_in;
    logic [FRAME_BITS-1:0] shift_out;
    logic dout;
    tsr_port_ev_s ev;
  } tsr_port_s;

  tsr_port_s s_q, s_d;

  // Frame image: leading zeros then the result, MSB first
  function automatic logic [FRAME_BITS-1:0] frame_of(input tsr_result_t r);
    frame_of = {{LEAD_ZEROS{1'b0}}, r};
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic [FRAME_BITS-1:0] image;
    rise = pins.sclk & ~s_q.sclk_prev & ~pins.cs_n;
    fall = ~pins.sclk & s_q.sclk_prev & ~pins.cs_n;
    image = frame_of(result);
    s_d = s_q;
    s_d.ev.first_fall = 1'b0;
    s_d.ev.access_end = 1'b0;
    s_d.ev.ctrl_load = 1'b0;
    s_d.sclk_prev = pins.sclk;
    if (pins.cs_n) begin
      if (s_q.active) begin
        s_d.ev.access_end = 1'b1;
      end
      s_d.active = 1'b0;
      s_d.seen_fall = 1'b0;
      s_d.fall_cnt = 4'h0;
      s_d.rise_cnt = 5'h00;
      s_d.dout = 1'b0;
    end else begin
      s_d.active = 1'b1;
      if (fall) begin
        // The first falling edge loads the result; wrap repeats frame
        if (!s_q.seen_fall) begin
          s_d.ev.first_fall = 1'b1;
          s_d.seen_fall = 1'b1;
        end
        // Result taken at the second fall, after the first-fall copy landed
        if (s_q.fall_cnt == 4'h0) begin
          s_d.dout = 1'b0;
        end else if (s_q.fall_cnt == 4'h1) begin
          s_d.shift_out = {image[FRAME_BITS-1-LEAD_ZEROS:0], {LEAD_ZEROS{1'b0}}};
          s_d.dout = 1'b0;
        end else begin
          s_d.dout = s_q.shift_out[FRAME_BITS-1];
          s_d.shift_out = {s_q.shift_out[FRAME_BITS-2:0], 1'b0};
        end
        s_d.fall_cnt = s_q.fall_cnt + 4'h1;
      end
      if (rise) begin
        s_d.shift_in = {s_q.shift_in[CTRL_W-2:0], pins.din};
        if (s_q.rise_cnt == 5'(FRAME_BITS - 1)) begin
          s_d.ev.ctrl_load = 1'b1;
          s_d.ev.ctrl_word = {s_q.shift_in[CTRL_W-2:0], pins.din};
          s_d.rise_cnt = 5'h00;
        end else begin
          s_d.rise_cnt = s_q.rise_cnt + 5'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.sclk_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Output drives only while selected, three-state otherwise
  assign dout_o = s_q.dout;
  assign dout_oe = s_q.active & ~pins.cs_n;
  assign ev = s_q.ev;

endmodule

// ===== dv/tsr_monitor.sv
/*
  Port checker for tsr_top: conversion timing, mode and output rules.
  Assumes it is bound into every tsr_top instance.
*/
`timescale 1ns/1ps
module tsr_monitor
  import tsr_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = 2000,
  parameter int unsigned CONVTIME_CYC = 100
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic analog_pwr,
  input wire logic conv_done,
  input tsr_result_t temperature_result,
  input wire logic shutdown
);
  int unsigned pwr_q;
  int unsigned idle_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Conversion length and idle gap in clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= 0;
      idle_q <= 0;
    end else begin
      pwr_q <= analog_pwr ? pwr_q + 1 : 0;
      idle_q <= (analog_pwr || shutdown || !cs_n) ? 0 : idle_q + 1;
    end
  end
  AST_CONV_LEN: assert property (pwr_q <= CONVTIME_CYC + 1)
    else $error("conversion too long");
  AST_CONV_END: assert property ($fell(analog_pwr) |-> $past(conv_done) ||
    $past(conv_done, 2) || pwr_q + 2 >= CONVTIME_CYC) else $error("conversion cut");
  AST_PERIOD: assert property (idle_q <= PERIOD_CYC + 4)
    else $error("periodic start missing");
  AST_ACC_CONV: assert property ($rose(cs_n) && !analog_pwr && !shutdown |-> ##[1:8] analog_pwr)
    else $error("no start after access");
  AST_SHDN_IDLE: assert property ((shutdown && !analog_pwr) ##1 shutdown |-> !analog_pwr)
    else $error("start in shutdown");
  AST_WAKE: assert property ($fell(shutdown) |-> ##[0:2] analog_pwr)
    else $error("no start on wake");
  AST_RESULT: assert property ($changed(temperature_result) |-> !$past(cs_n, 4))
    else $error("result moved off access");
  AST_SHDN_LOAD: assert property (shutdown != $past(shutdown) |-> $past(cs_n, 4) == 1'b0)
    else $error("mode moved off access");
  AST_DOUT_EDGE: assert property (dout_oe && $past(dout_oe) && $changed(dout_o) |->
    !$past(sclk, 3) || !$past(sclk, 4) || !$past(sclk, 5)) else $error("output moved off fall");
  // Main scenarios reached
  cover property ($rose(shutdown));
  cover property ($fell(shutdown));
  cover property (analog_pwr && conv_done);
endmodule

bind tsr_top tsr_monitor #(.PERIOD_CYC(PERIOD_CYC), .CONVTIME_CYC(CONVTIME_CYC)) mon_u (
  .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .dout_o(dout_o), .dout_oe(dout_oe),
  .analog_pwr(analog_pwr), .conv_done(conv_done),
  .temperature_result(temperature_result), .shutdown(shutdown));

// ===== dv/tsr_master_model.sv
/*
  Serial master: drives chip select, serial clock and data in.
  Assumes go rises once per access; timing is its own, not the system clock.
*/
`timescale 1ns/1ps
module tsr_master_model (
  input wire logic go,
  input wire logic [15:0] tx,
  input wire logic [5:0] nclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  output logic cs_n,
  output logic sclk,
  output logic din,
  output logic [31:0] rx,
  output logic busy
);
  localparam int HALF = 80;
  // One access per rising edge of go
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    rx = '0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #7 cs_n = 1'b0;
      #HALF;
      for (int i = 0; i < nclk; i++) begin
        sclk = 1'b0;
        din = tx[15 - (i % 16)];
        #HALF sclk = 1'b1;
        // Bit is stable over the whole high phase
        #HALF rx = {rx[30:0], dout_oe ? dout_o : ~rx[0]};
      end
      #40 cs_n = 1'b1;
      din = ~din; // Released line holds no level
      #HALF busy = 1'b0;
    end
  end
endmodule

// ===== dv/temp_sensor_serial_readout_tb.sv
/*
  Bench for tsr_top with a converter model and checks.
  Assumes tsr_master_model and the bound monitor.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module temp_sensor_serial_readout_tb
  import tsr_pkg::*;
();
  localparam int PER = 2000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, din, dout_o, dout_oe, analog_pwr, osc_run, shutdown, busy;
  logic conv_done = 1'b0;
  logic pwr_q = 1'b0;
  logic go = 1'b0;
  tsr_result_t conv_data = '0;
  tsr_result_t buf_exp = '0;
  tsr_result_t temperature_result, exp_v;
  logic [15:0] tx = '0;
  logic [15:0] w;
  logic [5:0] nclk = 6'h10;
  logic [31:0] rx;
  logic [31:0] seed = 32'h64f2085d;
  int conv_delay = 20, ccnt = 0, rises = 0, r0, bad_count = 0, tests_run = 0;

  initial forever #10 clock = ~clock;

  tsr_top #(.PERIOD_CYC(PER), .CONVTIME_CYC(100)) dut_u (.clock(clock), .rst_n(rst_n),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .analog_pwr(analog_pwr), .osc_run(osc_run), .conv_done(conv_done), .conv_data(conv_data),
    .temperature_result(temperature_result), .shutdown(shutdown));
  tsr_master_model mst_u (.go(go), .tx(tx), .nclk(nclk), .dout_o(dout_o), .dout_oe(dout_oe),
    .cs_n(cs_n), .sclk(sclk), .din(din), .rx(rx), .busy(busy));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] frame_of(input tsr_result_t r);
    return {2'b00, r};
  endfunction
  // Degrees times 32, as the master works them out from a read code
  function automatic logic [15:0] deg32(input tsr_result_t c);
    return c[SIGN_BIT_POSITION] ? 16'(c) - 16'h4000 : 16'(c);
  endfunction

  // Converter: new random code per conversion, done after conv_delay
  always @(posedge clock) begin
    seed <= lfsr(seed);
    pwr_q <= analog_pwr;
    conv_done <= analog_pwr && pwr_q && conv_delay != 0 && ccnt == conv_delay;
    ccnt <= analog_pwr ? ccnt + 1 : 0;
    if (analog_pwr && !pwr_q) begin
      conv_data <= seed[13:0];
      rises <= rises + 1;
    end
    if (!analog_pwr && pwr_q) buf_exp <= conv_data;
  end

  task automatic xfer(input logic [15:0] wd, input logic [5:0] n);
    int k;
    k = 0;
    @(posedge clock);
    tx <= wd;
    nclk <= n;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    while (busy === 1'b1 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000) begin
      bad_count++;
      $display("Error %0t: transfer never finished", $time);
    end
  endtask

  task automatic wait_pwr(input logic v);
    int k;
    k = 0;
    while (analog_pwr !== v && k < 4000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 4000) begin
      bad_count++;
      $display("Error %0t: converter power never settled", $time);
    end
    @(posedge clock);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    $display("Error %0t: watchdog expired", $time);
    close_out();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(temperature_result, 14'h0000)
    `CHK(shutdown, 1'b0)
    `CHK(dout_oe, 1'b0)
    `CHK(rises, 1)
    conv_delay = 40;
    wait_pwr(1'b0);
    exp_v = buf_exp;
    xfer(16'h0000, 6'd16);
    `CHK(rx[15:0], frame_of(exp_v))
    `CHK(temperature_result, exp_v)
    wait_pwr(1'b1);
    exp_v = buf_exp;
    xfer(16'h0000, 6'd16);
    `CHK(rx[15:0], frame_of(exp_v))
    `CHK(temperature_result, exp_v)
    $display("test read done");
    conv_delay = 0;
    wait_pwr(1'b0);
    r0 = rises;
    xfer(16'h0000, 6'd2);
    xfer(16'h0000, 6'd2);
    wait_pwr(1'b0);
    repeat (30) @(posedge clock);
    `CHK(rises, r0 + 1)
    conv_delay = 30;
    wait_pwr(1'b0);
    exp_v = buf_exp;
    xfer(16'h0000, 6'd32);
    `CHK(rx, {frame_of(exp_v), frame_of(exp_v)})
    xfer(16'h2000, 6'd10);
    `CHK(shutdown, 1'b0)
    $display("test frames done");
    wait_pwr(1'b0);
    exp_v = buf_exp;
    xfer(16'h2000, 6'd16);
    `CHK(shutdown, 1'b1)
    `CHK(osc_run, 1'b0)
    r0 = rises;
    repeat (PER + 100) @(posedge clock);
    `CHK(rises, r0)
    xfer(16'h2000, 6'd16);
    `CHK(rx[15:0], frame_of(exp_v))
    xfer(16'h0004, 6'd16);
    `CHK(shutdown, 1'b1)
    xfer(16'h0000, 6'd10);
    `CHK(shutdown, 1'b1)
    xfer(16'h0000, 6'd16);
    `CHK(shutdown, 1'b0)
    `CHK(analog_pwr, 1'b1)
    `CHK(osc_run, 1'b1)
    $display("test shutdown done");
    wait_pwr(1'b0);
    r0 = rises;
    repeat (PER + 20) @(posedge clock);
    `CHK(rises, r0 + 1)
    $display("test period done");
    for (int i = 0; i < 10; i++) begin
      conv_delay = seed[6:0];
      wait_pwr(1'b0);
      exp_v = buf_exp;
      w = {2'b00, seed[8], 13'h0000};
      xfer(w, seed[9] ? 6'd32 : 6'd16);
      `CHK(rx[15:0], frame_of(exp_v))
      `CHK(deg32(rx[13:0]), {{2{exp_v[13]}}, exp_v})
      `CHK(dout_oe, 1'b0)
      `CHK(temperature_result, exp_v)
      `CHK(shutdown, w[13])
    end
    $display("test random done");
    close_out();
  end
endmodule
